// ===== dcs_consts.svh
// Purpose: constants for the digital I/O and clock source configuration block
// Assumes: AXI4-Lite register access, one 10 MHz clock
// Notes: offsets are byte addresses of aligned 32-bit words
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH
`define DCS_OFF_CLOCK   8'h00
`define DCS_OFF_INOPT   8'h04
`define DCS_OFF_OUTOPT  8'h08
`define DCS_OFF_CLKSTAT 8'h0c
`define DCS_OFF_INSTAT  8'h10
`define DCS_OFF_FREQ    8'h14
`define DCS_OFF_ROUTE   8'h18
`define DCS_RESP_OKAY   2'b00
`define DCS_RESP_SLVERR 2'b10
`define DCS_SRC_INTERNAL 3'h0
`define DCS_NUM_INPUTS  6
`define DCS_RATE_48K    3'h2
`define DCS_RATE_MAX    3'h5
`define DCS_MADI_SPLIT_CH 7'h20
`define DCS_MADI_56_CH  7'h38
`define DCS_MADI_64_CH  7'h40
`endif

// ===== dcs_pkg.sv
// Purpose: shared types for the clock source configuration block
// Assumes: nothing beyond the constants header
// Notes: source codes: 0 internal, 1..6 word, AES, opt1, opt2, MADI opt, MADI coax
package dcs_pkg;
	typedef logic [2:0] dcs_src_t;
	typedef logic [2:0] dcs_rate_t;
	typedef enum logic [1:0] {DCS_NOLOCK, DCS_LOCK, DCS_SYNC} dcs_lock_e;
	typedef enum logic [1:0] {DCS_MIN_OPT, DCS_MIN_COAX, DCS_MIN_AUTO, DCS_MIN_SPLIT} dcs_madi_in_e;
	typedef enum logic [1:0] {DCS_MOUT_OPT, DCS_MOUT_MIRROR, DCS_MOUT_SPLIT} dcs_madi_out_e;
endpackage

// ===== dcs_config.sv
// Purpose: digital I/O routing and clock source selection with AXI4-Lite registers
// Assumes: cur_rate already in the aclk domain; lock, sync and rate pins are async
// Notes: inputs from pins pass two flip-flops before use
`include "dcs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dcs_config
	import dcs_pkg::*;
(
	input  wire logic        aclk,            // 10 MHz clock
	input  wire logic        aresetn,         // Sync reset, active low
	input  wire logic [7:0]  s_axi_awaddr,    // Write address
	input  wire logic        s_axi_awvalid,   // Write address valid
	output logic             s_axi_awready,   // Write address ready
	input  wire logic [31:0] s_axi_wdata,     // Write data
	input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
	input  wire logic        s_axi_wvalid,    // Write data valid
	output logic             s_axi_wready,    // Write data ready
	output logic [1:0]       s_axi_bresp,     // Write response
	output logic             s_axi_bvalid,    // Write response valid
	input  wire logic        s_axi_bready,    // Write response ready
	input  wire logic [7:0]  s_axi_araddr,    // Read address
	input  wire logic        s_axi_arvalid,   // Read address valid
	output logic             s_axi_arready,   // Read address ready
	output logic [31:0]      s_axi_rdata,     // Read data
	output logic [1:0]       s_axi_rresp,     // Read response
	output logic             s_axi_rvalid,    // Read valid
	input  wire logic        s_axi_rready,    // Read ready
	input  wire logic [5:0]  in_lock_pin,     // Lock per input, async
	input  wire logic [5:0]  in_sync_pin,     // Sync per input, async
	input  wire logic [17:0] in_rate_pin,     // Coarse rate code per input, async
	input  wire logic [2:0]  cur_rate,        // Current sample rate code
	output logic [2:0]       clk_src_used,    // Source in use, 0 internal
	output logic [2:0]       wc_out_rate,     // Word clock output rate code
	output logic             opt2_in_to_aes,  // Optical in 2 feeds AES receiver
	output logic             xlr_aes_enable,  // XLR AES receiver enabled
	output logic             opt2_out_aes,    // Optical out 2 carries AES
	output logic             aes_professional,// Pro channel status
	output logic             madi_in_opt_en,  // Optical MADI input active
	output logic             madi_in_coax_en, // Coaxial MADI input active
	output logic [6:0]       madi_in_opt_ch,  // Channels taken from optical
	output logic [6:0]       madi_in_coax_ch, // Channels taken from coaxial
	output logic [6:0]       madi_out_opt_ch, // Channels on optical output
	output logic [6:0]       madi_out_coax_ch,// Channels on coax, 0 gives word clock
	output logic             madi_out_split,  // Different channels on coax
	output logic             madi_frame_96k,  // Native 96K frame in use
	output logic             status_pass_en,  // Forward status and markers
	output logic             eq_dyn_in_path,  // Input EQ+dynamics in record path
	output logic             eq_dyn_out_path  // Output EQ+dynamics in record path
);
	// Register state
	logic [2:0]  clk_sel;
	logic        wc_single, opt2_in_sel, opt2_out_sel, aes_pro, tms_en, eqd_en, loopback_en;
	logic [1:0]  madi_in_mode, madi_out_mode;
	logic        madi_fmt64, madi_frame96;
	logic [5:0]  lock_m, lock_s, sync_m, sync_s;
	logic [17:0] rate_m, rate_s;
	logic [2:0]  src_used;
	logic        madi_auto_pick, madi_auto_done;
	logic        aw_hold, w_hold;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// Two-flop synchronisers for the pin inputs
	always_ff @(posedge aclk) begin
		lock_m <= in_lock_pin;
		lock_s <= lock_m;
		sync_m <= in_sync_pin;
		sync_s <= sync_m;
		rate_m <= in_rate_pin;
		rate_s <= rate_m;
	end

	// Per-input status: no lock, lock or sync
	logic [11:0] in_state;
	genvar gi;
	generate
		for (gi = 0; gi < `DCS_NUM_INPUTS; gi++) begin : g_stat
			assign in_state[2*gi +: 2] = !lock_s[gi] ? 2'(DCS_NOLOCK) :
				(sync_s[gi] ? 2'(DCS_SYNC) : 2'(DCS_LOCK));
		end
	endgenerate

	// AES lock counts only from the receiver actually in use
	logic [5:0] lock_eff;
	assign lock_eff = lock_s; // receiver mux upstream reports active AES input

	// Next locked input after the chosen one, wrapping
	function automatic logic [2:0] next_locked(input logic [2:0] sel, input logic [5:0] lk);
		logic [2:0] idx;
		logic [2:0] res;
		res = `DCS_SRC_INTERNAL;
		for (int k = 5; k >= 1; k--) begin
			idx = 3'(((int'(sel) - 1 + k) % 6) + 1);
			if (lk[idx - 3'h1]) begin
				res = idx;
			end
		end
		return res;
	endfunction

	// Selection is re-evaluated every cycle, so the chosen input wins back at once
	wire       sel_ext    = clk_sel != `DCS_SRC_INTERNAL;
	wire       sel_locked = sel_ext && lock_eff[clk_sel - 3'h1];
	wire [2:0] next_src_used = !sel_ext ? `DCS_SRC_INTERNAL :
		sel_locked ? clk_sel :
		next_locked(clk_sel, lock_eff);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_used <= `DCS_SRC_INTERNAL;
		end else begin
			src_used <= next_src_used;
		end
	end
	assign clk_src_used = src_used;

	// Word clock rate: clamp to 48k in single speed
	logic [2:0] next_wc;
	assign next_wc = (wc_single && cur_rate > `DCS_RATE_48K) ? `DCS_RATE_48K : cur_rate;

	// MADI auto pick latches the first port with a valid signal
	wire madi_opt_lock  = lock_s[4];
	wire madi_coax_lock = lock_s[5];
	always_ff @(posedge aclk) begin
		if (!aresetn || madi_in_mode != 2'(DCS_MIN_AUTO)) begin
			madi_auto_done <= 1'b0;
			madi_auto_pick <= 1'b0;
		end else if (!madi_auto_done && (madi_opt_lock || madi_coax_lock)) begin
			madi_auto_done <= 1'b1;
			madi_auto_pick <= !madi_opt_lock;
		end
	end

	wire min_split = madi_in_mode == 2'(DCS_MIN_SPLIT);
	wire min_coax  = madi_in_mode == 2'(DCS_MIN_COAX) ||
		(madi_in_mode == 2'(DCS_MIN_AUTO) && madi_auto_pick);
	wire [6:0] madi_full = madi_fmt64 ? `DCS_MADI_64_CH : `DCS_MADI_56_CH;
	wire mout_split  = madi_out_mode == 2'(DCS_MOUT_SPLIT);
	wire mout_mirror = madi_out_mode == 2'(DCS_MOUT_MIRROR);

	// Routing outputs registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wc_out_rate      <= 3'h0;
			opt2_in_to_aes   <= 1'b0;
			xlr_aes_enable   <= 1'b1;
			opt2_out_aes     <= 1'b0;
			aes_professional <= 1'b0;
			madi_in_opt_en   <= 1'b1;
			madi_in_coax_en  <= 1'b0;
			madi_in_opt_ch   <= 7'h0;
			madi_in_coax_ch  <= 7'h0;
			madi_out_opt_ch  <= 7'h0;
			madi_out_coax_ch <= 7'h0;
			madi_out_split   <= 1'b0;
			madi_frame_96k   <= 1'b0;
			status_pass_en   <= 1'b0;
			eq_dyn_in_path   <= 1'b0;
			eq_dyn_out_path  <= 1'b0;
		end else begin
			wc_out_rate      <= next_wc;
			opt2_in_to_aes   <= opt2_in_sel;
			xlr_aes_enable   <= !opt2_in_sel;
			opt2_out_aes     <= opt2_out_sel;
			aes_professional <= aes_pro;
			madi_in_opt_en   <= min_split || !min_coax;
			madi_in_coax_en  <= min_split || min_coax;
			madi_in_opt_ch   <= min_split ? `DCS_MADI_SPLIT_CH : (min_coax ? 7'h0 : madi_full);
			madi_in_coax_ch  <= min_split ? `DCS_MADI_SPLIT_CH : (min_coax ? madi_full : 7'h0);
			madi_out_opt_ch  <= mout_split ? `DCS_MADI_SPLIT_CH : madi_full;
			madi_out_coax_ch <= mout_split ? `DCS_MADI_SPLIT_CH :
				(mout_mirror ? madi_full : 7'h0);
			madi_out_split   <= mout_split;
			madi_frame_96k   <= madi_frame96 && cur_rate > `DCS_RATE_48K;
			status_pass_en   <= tms_en;
			eq_dyn_in_path   <= eqd_en && !loopback_en;
			eq_dyn_out_path  <= eqd_en && loopback_en;
		end
	end

	// AXI4-Lite write: address and data taken in either order
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	assign s_axi_awready = aresetn && !aw_hold && !s_axi_bvalid;
	assign s_axi_wready  = aresetn && !w_hold && !s_axi_bvalid;
	wire [7:0]  wr_addr = aw_take ? s_axi_awaddr : aw_addr;
	wire [31:0] wr_data = w_take ? s_axi_wdata : w_data;
	wire [3:0]  wr_strb = w_take ? s_axi_wstrb : w_strb;
	wire wr_go = (aw_take || aw_hold) && (w_take || w_hold);
	wire wr_ok = wr_addr == `DCS_OFF_CLOCK || wr_addr == `DCS_OFF_INOPT ||
		wr_addr == `DCS_OFF_OUTOPT;
	wire wr_b0 = wr_go && wr_ok && wr_strb[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold  <= 1'b0;
			aw_addr <= 8'h0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `DCS_RESP_OKAY;
		end else begin
			if (wr_go) begin
				aw_hold <= 1'b0;
				w_hold  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `DCS_RESP_OKAY : `DCS_RESP_SLVERR;
			end else begin
				if (aw_take) begin
					aw_hold <= 1'b1;
					aw_addr <= s_axi_awaddr;
				end
				if (w_take) begin
					w_hold <= 1'b1;
					w_data <= s_axi_wdata;
					w_strb <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end

	// Config fields all live in byte lane 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_sel <= `DCS_SRC_INTERNAL;
			wc_single <= 1'b0;
			opt2_in_sel <= 1'b0;
			madi_in_mode <= 2'(DCS_MIN_OPT);
			tms_en <= 1'b0;
			eqd_en <= 1'b0;
			loopback_en <= 1'b0;
			aes_pro <= 1'b0;
			opt2_out_sel <= 1'b0;
			madi_fmt64 <= 1'b1;
			madi_frame96 <= 1'b0;
			madi_out_mode <= 2'(DCS_MOUT_OPT);
		end else if (wr_b0) begin
			if (wr_addr == `DCS_OFF_CLOCK) begin
				clk_sel <= (wr_data[2:0] > 3'h6) ? `DCS_SRC_INTERNAL : wr_data[2:0];
				wc_single <= wr_data[4];
			end
			if (wr_addr == `DCS_OFF_INOPT) begin
				opt2_in_sel <= wr_data[0];
				madi_in_mode <= wr_data[2:1];
				tms_en <= wr_data[3];
				eqd_en <= wr_data[4];
				loopback_en <= wr_data[5];
			end
			if (wr_addr == `DCS_OFF_OUTOPT) begin
				aes_pro <= wr_data[0];
				opt2_out_sel <= wr_data[1];
				madi_fmt64 <= wr_data[2];
				madi_frame96 <= wr_data[3];
				madi_out_mode <= (wr_data[5:4] == 2'h3) ? 2'(DCS_MOUT_OPT) : wr_data[5:4];
			end
		end
	end

	// AXI4-Lite read, answer one cycle after address accepted
	assign s_axi_arready = aresetn && !s_axi_rvalid;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	logic [31:0] rd_word;
	logic        rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			`DCS_OFF_CLOCK:   rd_word = {27'h0, wc_single, 1'b0, clk_sel};
			`DCS_OFF_INOPT:   rd_word = {26'h0, loopback_en, eqd_en, tms_en, madi_in_mode, opt2_in_sel};
			`DCS_OFF_OUTOPT:  rd_word = {26'h0, madi_out_mode, madi_frame96, madi_fmt64,
				opt2_out_sel, aes_pro};
			`DCS_OFF_CLKSTAT: rd_word = {25'h0, next_wc, 1'b0, src_used};
			`DCS_OFF_INSTAT:  rd_word = {20'h0, in_state};
			`DCS_OFF_FREQ:    rd_word = {14'h0, rate_s};
			`DCS_OFF_ROUTE:   rd_word = {29'h0, madi_auto_done, madi_auto_pick, opt2_in_to_aes};
			default: begin
				rd_word = 32'h0;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `DCS_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_ok ? `DCS_RESP_OKAY : `DCS_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Checks
	// Selection may be rewritten in the same cycle, so compare with the old one
	a_fallback_src: assert property (@(posedge aclk) disable iff (!aresetn)
		sel_ext && !sel_locked |=> src_used != $past(clk_sel)) else $error("fallback kept dead source");
	a_internal_none: assert property (@(posedge aclk) disable iff (!aresetn)
		lock_eff == 6'h0 |=> src_used == `DCS_SRC_INTERNAL) else $error("no lock not internal");
	a_return_sel: assert property (@(posedge aclk) disable iff (!aresetn)
		sel_locked |=> src_used == $past(clk_sel)) else $error("not back on chosen source");
	a_used_locked: assert property (@(posedge aclk) disable iff (!aresetn)
		next_src_used != 3'h0 |-> lock_eff[next_src_used - 3'h1]) else $error("source unlocked");
	a_wc_clamp: assert property (@(posedge aclk) disable iff (!aresetn)
		wc_single |=> wc_out_rate <= `DCS_RATE_48K) else $error("word clock above 48k");
	a_xlr_off: assert property (@(posedge aclk) disable iff (!aresetn)
		opt2_in_sel |=> !xlr_aes_enable && opt2_in_to_aes) else $error("XLR AES not ignored");
	a_split_in: assert property (@(posedge aclk) disable iff (!aresetn)
		min_split |=> madi_in_opt_ch == 7'h20 && madi_in_coax_ch == 7'h20) else $error("bad split in");
	a_mirror_out: assert property (@(posedge aclk) disable iff (!aresetn)
		mout_mirror |=> madi_out_coax_ch == madi_out_opt_ch) else $error("mirror not copy");
	a_eqd_path: assert property (@(posedge aclk) disable iff (!aresetn)
		eqd_en |=> eq_dyn_out_path == $past(loopback_en) && eq_dyn_in_path != eq_dyn_out_path)
		else $error("wrong EQ path");
endmodule
`default_nettype wire

// ===== dcs_gear_model.sv
// Purpose: external digital gear as seen at the lock, sync and rate pins
// Assumes: the bench commands what each input offers
// Notes: sync is only shown with lock, as a real receiver reports it
`timescale 1ns/1ps
`default_nettype none
module dcs_gear_model (
	input  wire logic        aclk,     // Bench clock
	input  wire logic [5:0]  lock_cmd, // Lock wanted per input
	input  wire logic [5:0]  sync_cmd, // Sync wanted per input
	input  wire logic [17:0] rate_cmd, // Rate codes per input
	output logic [5:0]       lock_pin, // Lock to block
	output logic [5:0]       sync_pin, // Sync to block
	output logic [17:0]      rate_pin  // Rate codes to block
);
	always_ff @(posedge aclk) begin
		lock_pin <= lock_cmd;
		sync_pin <= sync_cmd & lock_cmd;
		rate_pin <= rate_cmd;
	end
endmodule
`default_nettype wire

// ===== dcs_config_tb.sv
// Purpose: self-checking bench for the clock source configuration block
// Assumes: AXI4-Lite master tasks, gear model on the status pins
// Notes: handshakes are sampled at the falling edge, stable since the rising one
`include "dcs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module dcs_config_tb;
	import dcs_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic [5:0]  lock_cmd, sync_cmd, in_lock_pin, in_sync_pin;
	logic [17:0] rate_cmd, in_rate_pin;
	logic [2:0]  cur_rate, clk_src_used, wc_out_rate;
	logic        opt2_in_to_aes, xlr_aes_enable, opt2_out_aes, aes_professional;
	logic        madi_in_opt_en, madi_in_coax_en, madi_out_split, madi_frame_96k;
	logic        status_pass_en, eq_dyn_in_path, eq_dyn_out_path;
	logic [6:0]  madi_in_opt_ch, madi_in_coax_ch, madi_out_opt_ch, madi_out_coax_ch;
	int          errors = 0;
	int          n_checks = 0;

	dcs_config dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_lock_pin,
		.in_sync_pin, .in_rate_pin, .cur_rate, .clk_src_used, .wc_out_rate,
		.opt2_in_to_aes, .xlr_aes_enable, .opt2_out_aes, .aes_professional,
		.madi_in_opt_en, .madi_in_coax_en, .madi_in_opt_ch, .madi_in_coax_ch,
		.madi_out_opt_ch, .madi_out_coax_ch, .madi_out_split, .madi_frame_96k,
		.status_pass_en, .eq_dyn_in_path, .eq_dyn_out_path);
	dcs_gear_model gear (.aclk, .lock_cmd, .sync_cmd, .rate_cmd,
		.lock_pin(in_lock_pin), .sync_pin(in_sync_pin), .rate_pin(in_rate_pin));

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic st(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int t;
		logic ha, hw, hb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		t = 0;
		hb = 1'b0;
		while (!hb && t < 50) begin
			@(negedge aclk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			hb = s_axi_bvalid;
			rr = s_axi_bresp;
			@(posedge aclk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
			t++;
		end
		s_axi_bready <= 1'b0;
		if (!hb) errors++;
	endtask

	task automatic axr(input logic [7:0] a);
		int t;
		logic ha, hr;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		t = 0;
		hr = 1'b0;
		while (!hr && t < 50) begin
			@(negedge aclk);
			ha = s_axi_arvalid && s_axi_arready;
			hr = s_axi_rvalid;
			rd = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge aclk);
			if (ha) s_axi_arvalid <= 1'b0;
			t++;
		end
		s_axi_rready <= 1'b0;
		if (!hr) errors++;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		axr(a);
		`CHECK_EQ(rd, e)
		`CHECK_EQ(rr, `DCS_RESP_OKAY)
	endtask

	task automatic wset(input logic [7:0] a, input logic [31:0] d);
		axw(a, d, 4'hf);
		st(3);
	endtask

	task automatic pins(input logic [5:0] l, input logic [5:0] s);
		@(posedge aclk);
		lock_cmd <= l;
		sync_cmd <= s;
		st(6);
	endtask

	task automatic rate(input logic [2:0] r);
		@(posedge aclk);
		cur_rate <= r;
		st(3);
	endtask

	task automatic endt(input string name);
		$display("test %s done: %0d checks, %0d errors", name, n_checks, errors);
	endtask

	task automatic give_verdict();
		$display("checks %0d, errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Whole run is under 2000 cycles; five times that means a hang
	initial begin
		#1000000;
		errors++;
		give_verdict();
	end

	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = '0;
		lock_cmd = '0;
		sync_cmd = '0;
		rate_cmd = 18'h2c688;
		cur_rate = 3'h4;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		st(2);
		`CHECK_EQ(clk_src_used, `DCS_SRC_INTERNAL)
		`CHECK_EQ(xlr_aes_enable, 1'b1)
		`CHECK_EQ(madi_in_opt_en, 1'b1)
		`CHECK_EQ(madi_out_opt_ch, `DCS_MADI_64_CH)
		`CHECK_EQ(madi_out_coax_ch, 7'h00)
		rchk(`DCS_OFF_OUTOPT, 32'h4);
		axr(8'h1c);
		`CHECK_EQ(rr, `DCS_RESP_SLVERR)
		`CHECK_EQ(rd, 32'h0)
		axw(`DCS_OFF_CLKSTAT, 32'h5, 4'hf);
		`CHECK_EQ(rr, `DCS_RESP_SLVERR)
		endt("reset_and_bus");
		pins(6'h3f, 6'h01);
		rchk(`DCS_OFF_INSTAT, 32'h556);
		rchk(`DCS_OFF_FREQ, 32'h2c688);
		for (int s = 1; s < 7; s++) begin
			wset(`DCS_OFF_CLOCK, s);
			`CHECK_EQ(clk_src_used, 3'(s))
		end
		wset(`DCS_OFF_CLOCK, 32'h2);
		pins(6'h3d, 6'h00);
		`CHECK_EQ(clk_src_used, 3'h3)
		pins(6'h01, 6'h00);
		`CHECK_EQ(clk_src_used, 3'h1)
		pins(6'h00, 6'h00);
		`CHECK_EQ(clk_src_used, `DCS_SRC_INTERNAL)
		rchk(`DCS_OFF_CLKSTAT, 32'h40);
		pins(6'h02, 6'h00);
		`CHECK_EQ(clk_src_used, 3'h2)
		rchk(`DCS_OFF_CLKSTAT, 32'h42);
		endt("clock_source");
		`CHECK_EQ(wc_out_rate, 3'h4)
		wset(`DCS_OFF_CLOCK, 32'h12);
		`CHECK_EQ(wc_out_rate, `DCS_RATE_48K)
		rate(3'h1);
		`CHECK_EQ(wc_out_rate, 3'h1)
		rate(`DCS_RATE_MAX);
		`CHECK_EQ(wc_out_rate, `DCS_RATE_48K)
		rate(3'h4);
		axw(`DCS_OFF_CLOCK, 32'h5, 4'he);
		rchk(`DCS_OFF_CLOCK, 32'h12);
		wset(`DCS_OFF_CLOCK, 32'h17);
		rchk(`DCS_OFF_CLOCK, 32'h10);
		endt("word_clock");
		wset(`DCS_OFF_INOPT, 32'h1);
		`CHECK_EQ(opt2_in_to_aes, 1'b1)
		`CHECK_EQ(xlr_aes_enable, 1'b0)
		wset(`DCS_OFF_INOPT, 32'h2);
		`CHECK_EQ({opt2_in_to_aes, madi_in_opt_en, madi_in_coax_en}, 3'b001)
		`CHECK_EQ(madi_in_coax_ch, `DCS_MADI_64_CH)
		`CHECK_EQ(xlr_aes_enable, 1'b1)
		wset(`DCS_OFF_INOPT, 32'h6);
		`CHECK_EQ({madi_in_opt_en, madi_in_coax_en}, 2'b11)
		`CHECK_EQ({madi_in_opt_ch, madi_in_coax_ch}, {2{`DCS_MADI_SPLIT_CH}})
		pins(6'h20, 6'h00);
		wset(`DCS_OFF_INOPT, 32'h4);
		pins(6'h30, 6'h00);
		`CHECK_EQ({madi_in_opt_en, madi_in_coax_en}, 2'b01)
		rchk(`DCS_OFF_ROUTE, 32'h6);
		wset(`DCS_OFF_INOPT, 32'h0);
		wset(`DCS_OFF_INOPT, 32'h4);
		`CHECK_EQ({madi_in_opt_en, madi_in_coax_en}, 2'b10)
		wset(`DCS_OFF_INOPT, 32'h18);
		`CHECK_EQ({status_pass_en, eq_dyn_in_path, eq_dyn_out_path}, 3'b110)
		wset(`DCS_OFF_INOPT, 32'h30);
		`CHECK_EQ({status_pass_en, eq_dyn_in_path, eq_dyn_out_path}, 3'b001)
		endt("input_options");
		wset(`DCS_OFF_OUTOPT, 32'h1);
		`CHECK_EQ({aes_professional, opt2_out_aes}, 2'b10)
		`CHECK_EQ(madi_out_opt_ch, `DCS_MADI_56_CH)
		wset(`DCS_OFF_OUTOPT, 32'h2);
		`CHECK_EQ({aes_professional, opt2_out_aes}, 2'b01)
		wset(`DCS_OFF_OUTOPT, 32'h0c);
		`CHECK_EQ(madi_frame_96k, 1'b1)
		rate(`DCS_RATE_48K);
		`CHECK_EQ(madi_frame_96k, 1'b0)
		`CHECK_EQ(madi_out_opt_ch, `DCS_MADI_64_CH)
		wset(`DCS_OFF_OUTOPT, 32'h10);
		`CHECK_EQ({madi_out_opt_ch, madi_out_coax_ch}, {2{`DCS_MADI_56_CH}})
		wset(`DCS_OFF_OUTOPT, 32'h24);
		`CHECK_EQ({madi_out_opt_ch, madi_out_coax_ch}, {2{`DCS_MADI_SPLIT_CH}})
		`CHECK_EQ(madi_out_split, 1'b1)
		rchk(`DCS_OFF_OUTOPT, 32'h24);
		endt("output_options");
		aresetn <= 1'b0;
		st(2);
		aresetn <= 1'b1;
		st(2);
		rchk(`DCS_OFF_OUTOPT, 32'h4);
		`CHECK_EQ(madi_out_coax_ch, 7'h00)
		`CHECK_EQ(xlr_aes_enable, 1'b1)
		endt("second_reset");
		give_verdict();
	end
endmodule
`default_nettype wire
